// file: core/power_status_pkg.sv
// Constants shared by the power status, wake and reset cause block
package power_status_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] SUPPLY_STATUS_IDX = 16'h00f9;
  localparam logic [ADDR_W-1:0] WAKE_DURATION_IDX = 16'h2880;
  localparam logic [ADDR_W-1:0] RESET_CAUSE_IDX   = 16'h28b0;
  localparam logic [ADDR_W-1:0] WAKE_SOURCE_IDX   = 16'h28b1;
  localparam logic [ADDR_W-1:0] WAKE_ARM_IDX      = 16'h28b2;
  localparam logic [ADDR_W-1:0] WD_RESTART_IDX    = 16'h28b4;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_IDX    = 16'h2900;
  localparam logic [ADDR_W-1:0] IRQ_MASK_IDX      = 16'h2901;
  localparam logic [ADDR_W-1:0] WAKE_ENABLE_IDX   = 16'h2902;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int WAKE_ARM_BIT   = 5;
  localparam int WD_RESTART_BIT = 7;
  localparam int CAUSE_LSB      = 2;
  localparam int WF_TIMER       = 5;
  localparam int WF_RECEIVE     = 4;
  localparam int WF_BUTTON      = 3;
  localparam int WF_PIN4        = 2;
  localparam int WF_PIN52       = 1;
  localparam int WF_PIN55       = 0;
  localparam int IRQ_W          = 6;
  localparam int IRQ_TIMER      = 0;
  localparam int IRQ_PIN        = 1;
  localparam int IRQ_BUTTON     = 2;
  localparam int IRQ_RECEIVE    = 3;
  localparam int IRQ_WATCHDOG   = 4;
  localparam int IRQ_SUPPLY     = 5;

  // ----------------------------------------------------------------
  // Supply status codes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] SUP_MAIN_OK   = 3'h0;
  localparam logic [2:0] SUP_MAIN_LOW  = 3'h1;
  localparam logic [2:0] SUP_BAT_OK    = 3'h2;
  localparam logic [2:0] SUP_BAT_LOW   = 3'h3;
  localparam logic [2:0] SUP_BAT_FAIL  = 3'h5;
  localparam logic [7:0] DURATION_RST  = 8'h00;
  localparam logic [5:0] FLAGS_RST     = 6'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 40;
  localparam int SECOND_NS       = 1000000000;
  localparam int CYCLES_PER_SEC  = SECOND_NS / CLK_PERIOD_NS;
  localparam int DEBOUNCE_NS     = 160;
  localparam int DEBOUNCE_CYCLES = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WDT_SECONDS     = 2;

endpackage : power_status_pkg

// file: core/wake_reset_power_status.sv
// Supply status, wake timer, wake flags, reset cause and watchdog restart
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module wake_reset_power_status #(
  parameter int TICK_CYCLES = power_status_pkg::CYCLES_PER_SEC,
  parameter int DEB_CYCLES  = power_status_pkg::DEBOUNCE_CYCLES,
  parameter int WDT_SECS    = power_status_pkg::WDT_SECONDS
) (
  input  wire logic                              ref_clk,
  input  wire logic                              nrst,
  input  wire logic [power_status_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [power_status_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [power_status_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [power_status_pkg::DATA_W-1:0]    s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  input  wire logic                              analog_supply_good,
  input  wire logic                              system_supply_good,
  input  wire logic                              digital_supply_good,
  input  wire logic                              digital_supply_above_two,
  input  wire logic                              supply_trim_fuse,
  input  wire logic                              general_pin_4,
  input  wire logic                              general_pin_52,
  input  wire logic                              general_pin_55,
  input  wire logic                              pushbutton_input,
  input  wire logic                              receive_line,
  input  wire logic [5:0]                        reset_cause_in,
  input  wire logic                              sleep_request,
  input  wire logic                              display_only_request,
  output logic [2:0]                             supply_status_code,
  output logic                                   flash_write_inhibit,
  output logic                                   fast_pll_clear,
  output logic                                   wake_event,
  output logic                                   watchdog_restart_pulse,
  output logic                                   watchdog_overflow,
  output logic                                   irq
);
  import power_status_pkg::*;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (TICK_CYCLES < 2 || DEB_CYCLES < 1 || DEB_CYCLES > 255 || WDT_SECS < 1 || WDT_SECS > 255)
  begin : g_param_check
    $error("wake_reset_power_status: unsupported parameter");
  end

  // Word index of a byte address
  function automatic logic [ADDR_W-1:0] word_idx(input logic [ADDR_W-1:0] a);
    word_idx = {2'b00, a[ADDR_W-1:2]};
  endfunction : word_idx

  // Address maps onto a register
  function automatic logic mapped(input logic [ADDR_W-1:0] i);
    mapped = (i == SUPPLY_STATUS_IDX) || (i == WAKE_DURATION_IDX) || (i == RESET_CAUSE_IDX)
          || (i == WAKE_SOURCE_IDX) || (i == WAKE_ARM_IDX) || (i == WD_RESTART_IDX)
          || (i == IRQ_STATUS_IDX) || (i == IRQ_MASK_IDX) || (i == WAKE_ENABLE_IDX);
  endfunction : mapped

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [15:0] meta_reg;
  logic [15:0] sync_reg;
  logic [15:0] raw_in;

  assign raw_in = {reset_cause_in, receive_line, pushbutton_input, general_pin_4,
                   general_pin_52, general_pin_55, supply_trim_fuse, digital_supply_above_two,
                   digital_supply_good, system_supply_good, analog_supply_good};

  // Two flip-flops on every pin input
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_reg <= 16'h0200;  // Receive line idles high
      sync_reg <= 16'h0200;
    end
    else
    begin
      meta_reg <= raw_in;
      sync_reg <= meta_reg;
    end
  end

  logic       a_ok, s_ok, d_ok, d_gt2, fuse_s;
  logic [2:0] pin_s;
  logic       button_s, rx_s;
  logic [5:0] cause_s;

  assign {cause_s, rx_s, button_s, pin_s, fuse_s, d_gt2, d_ok, s_ok, a_ok} = sync_reg;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]       duration_reg;
  logic             arm_reg;
  logic [5:0]       wake_flags_reg;
  logic [5:0]       cause_reg;
  logic [1:0]       cause_wait_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [2:0]       wake_enable_reg;
  logic [2:0]       supply_reg;

  // ----------------------------------------------------------------
  // Supply status decode
  // ----------------------------------------------------------------
  logic [2:0] supply_next;
  logic       sup_valid;

  // Synced supply inputs are trusted from the third edge after reset
  assign sup_valid = cause_wait_reg[1];

  always_comb
  begin
    if (a_ok && s_ok)
      supply_next = SUP_MAIN_OK;
    else if (s_ok)
      supply_next = SUP_MAIN_LOW;
    else if (d_ok && d_gt2)
      supply_next = SUP_BAT_OK;
    else if (d_gt2)
      supply_next = SUP_BAT_LOW;
    else
      supply_next = SUP_BAT_FAIL;
  end

  // Registered code, flash inhibit and fast PLL clear strobe
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      supply_reg          <= SUP_MAIN_OK;
      flash_write_inhibit <= 1'b0;
      fast_pll_clear      <= 1'b0;
    end
    else if (sup_valid)
    begin
      supply_reg          <= supply_next;
      flash_write_inhibit <= (supply_next == SUP_BAT_LOW) || (supply_next == SUP_BAT_FAIL);
      fast_pll_clear      <= fuse_s && (supply_next == SUP_BAT_LOW) && (supply_reg != SUP_BAT_LOW);
    end
  end

  assign supply_status_code = supply_reg;

  // ----------------------------------------------------------------
  // One-hertz tick divider
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt_reg;
  logic        tick;

  assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      tick_cnt_reg <= 32'h0000_0000;
    else if (tick)
      tick_cnt_reg <= 32'h0000_0000;
    else
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic              aw_held_reg, w_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [DATA_W-1:0] w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              do_write;
  logic [ADDR_W-1:0] wr_idx;
  logic              wr_lo;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_idx        = word_idx(aw_addr_reg);
  assign wr_lo         = do_write && w_strb_reg[0];

  // Address and data taken in either order, answered once both are in
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      aw_addr_reg  <= '0;
      w_data_reg   <= '0;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  logic wr_duration, wr_arm, wr_restart, wr_flags, wr_status, wr_mask, wr_enable;

  assign wr_duration = wr_lo && (wr_idx == WAKE_DURATION_IDX);
  assign wr_arm      = wr_lo && (wr_idx == WAKE_ARM_IDX) && w_data_reg[WAKE_ARM_BIT];
  assign wr_restart  = wr_lo && (wr_idx == WD_RESTART_IDX) && w_data_reg[WD_RESTART_BIT];
  assign wr_flags    = wr_lo && (wr_idx == WAKE_SOURCE_IDX);
  assign wr_status   = wr_lo && (wr_idx == IRQ_STATUS_IDX);
  assign wr_mask     = wr_lo && (wr_idx == IRQ_MASK_IDX);
  assign wr_enable   = wr_lo && (wr_idx == WAKE_ENABLE_IDX);

  // Plain read/write control registers
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      duration_reg    <= DURATION_RST;
      irq_mask_reg    <= '0;
      wake_enable_reg <= 3'h0;
    end
    else
    begin
      if (wr_duration)
        duration_reg <= w_data_reg[7:0];
      if (wr_mask)
        irq_mask_reg <= w_data_reg[IRQ_W-1:0];
      if (wr_enable)
        wake_enable_reg <= w_data_reg[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Wake timer
  // ----------------------------------------------------------------
  logic [7:0] wake_cnt_reg;
  logic       asleep;
  logic       expire;

  assign asleep = sleep_request || display_only_request;
  assign expire = arm_reg && asleep && tick && (wake_cnt_reg == 8'h00);

  // Arming loads the duration; ticks count down while asleep
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      arm_reg      <= 1'b0;
      wake_cnt_reg <= 8'h00;
      wake_event   <= 1'b0;
    end
    else
    begin
      wake_event <= expire;
      if (wr_arm)
      begin
        arm_reg      <= 1'b1;
        wake_cnt_reg <= duration_reg;
      end
      else if (expire)
        arm_reg <= 1'b0;
      else if (arm_reg && asleep && tick)
        wake_cnt_reg <= wake_cnt_reg - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog restart and overflow
  // ----------------------------------------------------------------
  logic [7:0] wd_cnt_reg;
  logic       wd_over;

  assign wd_over = tick && (wd_cnt_reg == 8'(WDT_SECS - 1));

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wd_cnt_reg             <= 8'h00;
      watchdog_restart_pulse <= 1'b0;
      watchdog_overflow      <= 1'b0;
    end
    else
    begin
      watchdog_restart_pulse <= wr_restart;
      watchdog_overflow      <= wd_over && !wr_restart;
      if (wr_restart || wd_over)
        wd_cnt_reg <= 8'h00;
      else if (tick)
        wd_cnt_reg <= wd_cnt_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Pin debounce and edge detect
  // ----------------------------------------------------------------
  logic [7:0] deb_cnt_reg [3];
  logic [2:0] deb_reg;
  logic [2:0] deb_prev_reg;
  logic [2:0] pin_rise;

  // Debounced level follows the pin after it stays steady
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < 3; i++)
        deb_cnt_reg[i] <= 8'h00;
      deb_reg      <= 3'h0;
      deb_prev_reg <= 3'h0;
    end
    else
    begin
      deb_prev_reg <= deb_reg;
      for (int i = 0; i < 3; i++)
      begin
        if (pin_s[i] == deb_reg[i])
          deb_cnt_reg[i] <= 8'h00;
        else if (deb_cnt_reg[i] == 8'(DEB_CYCLES - 1))
        begin
          deb_reg[i]     <= pin_s[i];
          deb_cnt_reg[i] <= 8'h00;
        end
        else
          deb_cnt_reg[i] <= deb_cnt_reg[i] + 8'h01;
      end
    end
  end

  assign pin_rise = deb_reg & ~deb_prev_reg;

  // ----------------------------------------------------------------
  // Wake source flags
  // ----------------------------------------------------------------
  logic button_prev_reg, rx_prev_reg;
  logic button_wake, rx_wake;
  logic [5:0] wake_set;

  assign button_wake = asleep && button_s && !button_prev_reg;
  assign rx_wake     = asleep && !rx_s && rx_prev_reg;  // start bit falls
  assign wake_set    = {expire, rx_wake, button_wake, pin_rise & wake_enable_reg};

  // Sticky flags, a set outweighs a clear in the same cycle
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wake_flags_reg  <= FLAGS_RST;
      button_prev_reg <= 1'b0;
      rx_prev_reg     <= 1'b1;
    end
    else
    begin
      button_prev_reg <= button_s;
      rx_prev_reg     <= rx_s;
      wake_flags_reg  <= ((wake_flags_reg & ~(wr_flags ? w_data_reg[5:0] : 6'h00)) | wake_set)
                         & {3'h7, wake_enable_reg};
    end
  end

  // ----------------------------------------------------------------
  // Reset cause capture
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cause_wait_reg <= 2'h0;
      cause_reg      <= 6'h00;
    end
    else if (cause_wait_reg != 2'h3)
    begin
      cause_wait_reg <= cause_wait_reg + 2'h1;
      if (cause_wait_reg == 2'h2)
        cause_reg <= cause_s;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and output
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_set;

  assign irq_set = {sup_valid && (supply_next != supply_reg), wd_over, rx_wake, button_wake,
                    |(pin_rise & wake_enable_reg), expire};

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_status_reg <= '0;
      irq            <= 1'b0;
    end
    else
    begin
      irq_status_reg <= (irq_status_reg & ~(wr_status ? w_data_reg[IRQ_W-1:0] : '0)) | irq_set;
      irq            <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] rd_idx;
  logic [DATA_W-1:0] rd_word;

  assign rd_idx        = word_idx(s_axi_araddr);
  assign s_axi_arready = !s_axi_rvalid;

  always_comb
  begin
    rd_word = '0;
    case (rd_idx)
      SUPPLY_STATUS_IDX: rd_word[2:0] = supply_reg;
      WAKE_DURATION_IDX: rd_word[7:0] = duration_reg;
      RESET_CAUSE_IDX:   rd_word[CAUSE_LSB +: 6] = cause_reg;
      WAKE_SOURCE_IDX:   rd_word[5:0] = wake_flags_reg;
      WAKE_ARM_IDX:      rd_word[WAKE_ARM_BIT] = arm_reg;
      IRQ_STATUS_IDX:    rd_word[IRQ_W-1:0] = irq_status_reg;
      IRQ_MASK_IDX:      rd_word[IRQ_W-1:0] = irq_mask_reg;
      WAKE_ENABLE_IDX:   rd_word[2:0] = wake_enable_reg;
      default:           rd_word = '0;
    endcase
  end

  // One read in flight, answered the cycle after address acceptance
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule : wake_reset_power_status

`default_nettype wire

// file: verif/wake_reset_power_status_assertions.sv
// Port checker for the power status, wake and watchdog block
`timescale 1ns/1ps
`default_nettype none
module power_status_checker (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       analog_supply_good,
  input wire logic       system_supply_good,
  input wire logic       digital_supply_good,
  input wire logic       digital_supply_above_two,
  input wire logic       sleep_request,
  input wire logic       display_only_request,
  input wire logic [2:0] supply_status_code,
  input wire logic       flash_write_inhibit,
  input wire logic       fast_pll_clear,
  input wire logic       wake_event,
  input wire logic       watchdog_restart_pulse,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       irq
);
  logic [3:0] sv;
  // Supply inputs as one nibble
  assign sv = {analog_supply_good, system_supply_good, digital_supply_good, digital_supply_above_two};
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  // ------------------------------------------------------------
  // Supply decode, given sync and register latency
  // ------------------------------------------------------------
  a_code_main: assert property ((sv[3:2] == 2'b11) [*4] |=> supply_status_code == 3'h0)
    else $error("supply code not main ok");
  a_code_low: assert property ((sv[3:2] == 2'b01) [*4] |=> supply_status_code == 3'h1)
    else $error("supply code not main low");
  a_code_bat: assert property ((sv == 4'b0011) [*4] |=> supply_status_code == 3'h2)
    else $error("supply code not battery ok");
  a_inhibit_low: assert property ((sv == 4'b0001) [*4] |=>
    supply_status_code == 3'h3 && flash_write_inhibit) else $error("low battery not inhibited");
  a_code_fail: assert property ((sv[3:2] == 2'b00 && !sv[0]) [*4] |=>
    supply_status_code == 3'h5 && flash_write_inhibit) else $error("failing supply not flagged");
  a_pll_entry: assert property (fast_pll_clear |-> supply_status_code == 3'h3)
    else $error("pll clear outside low battery");
  // ------------------------------------------------------------
  // Wake timer and watchdog
  // ------------------------------------------------------------
  a_wake_asleep: assert property (wake_event |-> $past(sleep_request || display_only_request))
    else $error("wake while not asleep");
  a_wake_pulse: assert property (wake_event |=> !wake_event)
    else $error("wake pulse too long");
  a_restart_resp: assert property (watchdog_restart_pulse |-> ##[0:1] s_axi_bvalid)
    else $error("restart without write");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  c_wake: cover property (wake_event);
  c_restart: cover property (watchdog_restart_pulse);
  c_irq: cover property (irq);
  c_pll: cover property (fast_pll_clear);
endmodule : power_status_checker
bind wake_reset_power_status power_status_checker chk (.*);
`default_nettype wire

// file: verif/testbench.sv
// Bench for the power status, wake and watchdog block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import power_status_pkg::*;
  logic        ref_clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        irq, wake_event, watchdog_overflow, flash_write_inhibit, fast_pll_clear;
  logic        watchdog_restart_pulse, supply_trim_fuse, pushbutton_input, receive_line;
  logic        sleep_request, display_only_request;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb, sv;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0]  supply_status_code, gp;
  logic [5:0]  reset_cause_in;
  logic [6:0]  tv [5] = '{7'h78, 7'h39, 7'h1a, 7'h0b, 7'h05};
  int          failures = 0, samples_checked = 0, cyc = 0, wdp = 0, pcp = 0, wov = 0, n;
  wire analog_supply_good = sv[3], system_supply_good = sv[2];
  wire digital_supply_good = sv[1], digital_supply_above_two = sv[0];
  wire general_pin_4 = gp[2], general_pin_52 = gp[1], general_pin_55 = gp[0];
  wake_reset_power_status #(.TICK_CYCLES(10)) uut (.*);
  // Clock and cycle ceiling
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      close_out();
    end
  end
  // Count restart, fast PLL clear and overflow pulses
  always @(negedge ref_clk)
  begin
    if (watchdog_restart_pulse === 1'b1) wdp++;
    if (fast_pll_clear === 1'b1) pcp++;
    if (watchdog_overflow === 1'b1) wov++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] i, input logic [31:0] d);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= 16'(i * 4);
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(a && w))
    begin
      @(negedge ref_clk);
      a = a | s_axi_awready;
      w = w | s_axi_wready;
      @(posedge ref_clk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(negedge ref_clk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    @(posedge ref_clk);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] i);
    @(posedge ref_clk);
    s_axi_araddr <= 16'(i * 4);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge ref_clk); while (s_axi_arready !== 1'b1);
    @(posedge ref_clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge ref_clk); while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge ref_clk);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic close_out();
    if (failures == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  // Main sequence
  initial
  begin
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, gp} = '0;
    {sleep_request, display_only_request, pushbutton_input} = 3'h0;
    {receive_line, supply_trim_fuse, s_axi_wstrb, sv, reset_cause_in} = {2'h3, 4'hf, 4'hf, 6'h20};
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rd(RESET_CAUSE_IDX);
    chk(rdat, 32'h80);
    foreach (tv[k])
    begin
      sv <= tv[k][6:3];
      repeat (6) @(posedge ref_clk);
      rd(SUPPLY_STATUS_IDX);
      chk(rdat, 32'(tv[k][2:0]));
      @(negedge ref_clk);
      chk(flash_write_inhibit, 32'(tv[k][2:0] >= 3'h3));
    end
    supply_trim_fuse <= 1'b0;
    sv <= 4'h1;
    repeat (6) @(posedge ref_clk);
    chk(pcp, 1);
    sv <= 4'hf;
    repeat (6) @(posedge ref_clk);
    chk(irq, 0);
    wr(IRQ_MASK_IDX, 32'h20);
    repeat (3) @(negedge ref_clk);
    chk(irq, 1);
    wr(IRQ_STATUS_IDX, 32'h20);
    repeat (3) @(negedge ref_clk);
    chk(irq, 0);
    wr(WAKE_DURATION_IDX, 32'h2);
    rd(WAKE_DURATION_IDX);
    chk(rdat, 32'h2);
    wr(WAKE_ARM_IDX, 32'h20);
    repeat (60) @(posedge ref_clk);
    rd(WAKE_ARM_IDX);
    chk(rdat, 32'h20);
    sleep_request <= 1'b1;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (wake_event !== 1'b1 && n < 100);
    chk(32'(n >= 21 && n <= 32), 1);
    @(posedge ref_clk);
    sleep_request <= 1'b0;
    rd(WAKE_SOURCE_IDX);
    chk(rdat, 32'h20);
    wr(WAKE_SOURCE_IDX, 32'h3f);
    for (int i = 0; i < 3; i++)
    begin
      wr(WAKE_ENABLE_IDX, 32'h0);
      gp <= 3'(1 << i);
      repeat (12) @(posedge ref_clk);
      gp <= 3'h0;
      rd(WAKE_SOURCE_IDX);
      chk(rdat, 32'h0);
      wr(WAKE_ENABLE_IDX, 32'(1 << i));
      gp <= 3'(1 << i);
      repeat (12) @(posedge ref_clk);
      gp <= 3'h0;
      rd(WAKE_SOURCE_IDX);
      chk(rdat, 32'(1 << i));
      wr(WAKE_SOURCE_IDX, 32'h3f);
    end
    for (int i = 0; i < 2; i++)
    begin
      sleep_request <= 1'(i == 0);
      display_only_request <= 1'(i == 1);
      pushbutton_input <= 1'b1;
      receive_line <= 1'(i == 0);
      repeat (8) @(posedge ref_clk);
      sleep_request <= 1'b0;
      display_only_request <= 1'b0;
      rd(WAKE_SOURCE_IDX);
      chk(rdat, 32'h8 << i);
      wr(WAKE_SOURCE_IDX, 32'h3f);
    end
    wr(WD_RESTART_IDX, 32'h80);
    wr(WD_RESTART_IDX, 32'h80);
    wov = 0;
    repeat (10) @(negedge ref_clk);
    chk(wov, 0);
    repeat (11) @(negedge ref_clk);
    chk(wov, 1);
    wr(WD_RESTART_IDX, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk(wdp, 2);
    rd(16'h0100);
    chk(rsp, RESP_SLVERR);
    close_out();
  end
endmodule : testbench
`default_nettype wire
